// >>> rtl/bst_map.vh
`ifndef BST_MAP_VH
`define BST_MAP_VH

// Instruction register
`define BST_IR_LEN         10
`define BST_IR_CAPT        10'h001
`define BST_OP_EXTEST      10'h000
`define BST_OP_CFG_LOAD    10'h002
`define BST_OP_CFG_START   10'h003
`define BST_OP_SAMPLE      10'h005
`define BST_OP_IDCODE      10'h006
`define BST_OP_USERCODE    10'h007
`define BST_OP_LA_READ     10'h00E
`define BST_OP_BYPASS      10'h3FF

// Data register lengths
`define BST_WORD_LEN       32
`define BST_BSR_LEN_SMALL  1125
`define BST_BSR_LEN_LARGE  1695

// Identification fields (values arbitrary)
`define BST_ID_VERSION     4'h1
`define BST_ID_PART        16'h5A5A
`define BST_ID_MAKER       11'h2B5
`define BST_ID_FIXED       1'h1

// Reset values
`define BST_TDO_RST        1'h0
`define BST_BYP_RST        1'h0

`endif

// >>> rtl/bst_tap.v
`include "bst_map.vh"

module bst_tap #(
  parameter BSR_LEN = `BST_BSR_LEN_SMALL
) (
  input  wire                      clock,
  input  wire                      reset_n,
  input  wire                      tck,
  input  wire                      tms,
  input  wire                      tdi,
  output reg                       tdo_o,
  output reg                       tdo_oe,
  input  wire [`BST_WORD_LEN-1:0]  user_code,
  input  wire [`BST_WORD_LEN-1:0]  la_probe,
  input  wire [BSR_LEN-1:0]        pin_in,
  input  wire [BSR_LEN-1:0]        core_out,
  output reg  [BSR_LEN-1:0]        pin_out,
  output reg                       extest_active,
  output reg                       cfg_bit,
  output reg                       cfg_strobe,
  output reg                       cfg_start,
  output reg  [`BST_IR_LEN-1:0]    instr_out
);

  // Controller states, one-hot
  localparam [15:0] S_TLR  = 16'h0001;
  localparam [15:0] S_RTI  = 16'h0002;
  localparam [15:0] S_SELD = 16'h0004;
  localparam [15:0] S_CAPD = 16'h0008;
  localparam [15:0] S_SHD  = 16'h0010;
  localparam [15:0] S_EX1D = 16'h0020;
  localparam [15:0] S_PAUD = 16'h0040;
  localparam [15:0] S_EX2D = 16'h0080;
  localparam [15:0] S_UPDD = 16'h0100;
  localparam [15:0] S_SELI = 16'h0200;
  localparam [15:0] S_CAPI = 16'h0400;
  localparam [15:0] S_SHI  = 16'h0800;
  localparam [15:0] S_EX1I = 16'h1000;
  localparam [15:0] S_PAUI = 16'h2000;
  localparam [15:0] S_EX2I = 16'h4000;
  localparam [15:0] S_UPDI = 16'h8000;

  localparam [`BST_WORD_LEN-1:0] ID_VALUE =
    {`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MAKER, `BST_ID_FIXED};

  // Pin synchronisers; first stage feeds only the second
  reg  [2:0]              sync1_r;
  reg  [2:0]              sync2_r;
  reg                     tck_d_r;
  wire                    tck_s;
  wire                    tms_s;
  wire                    tdi_s;
  wire                    tck_rise;
  wire                    tck_fall;

  reg  [15:0]             state_r;
  reg  [15:0]             state_nxt;
  reg  [`BST_IR_LEN-1:0]  ir_sr_r;
  reg  [`BST_IR_LEN-1:0]  instr_r;
  reg                     byp_r;
  reg                     cfg_sr_r;
  wire [`BST_WORD_LEN-1:0] id_sr_r;
  wire [`BST_WORD_LEN-1:0] user_sr_r;
  wire [`BST_WORD_LEN-1:0] la_sr_r;
  wire                    cap_dr;
  wire                    shift_dr;
  reg  [BSR_LEN-1:0]      bsr_sr_r;
  reg  [BSR_LEN-1:0]      bsr_upd_r;

  reg                     sel_ext;
  reg                     sel_smp;
  reg                     sel_id;
  reg                     sel_user;
  reg                     sel_cfg;
  reg                     sel_la;
  reg                     sel_byp;
  reg                     dr_bit;

  assign tck_s    = sync2_r[2];
  assign tms_s    = sync2_r[1];
  assign tdi_s    = sync2_r[0];
  assign tck_rise = tck_s & ~tck_d_r;
  assign tck_fall = ~tck_s & tck_d_r;
  assign cap_dr   = tck_rise & (state_r == S_CAPD);
  assign shift_dr = tck_rise & (state_r == S_SHD);

  // Two flops on every test pin; tms/tdi keep pace with tck
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      tck_d_r <= 1'h0;
    end else begin
      sync1_r <= {tck, tms, tdi};
      sync2_r <= sync1_r;
      tck_d_r <= sync2_r[2];
    end
  end

  // Next controller state from sampled tms
  always @* begin
    case (state_r)
      S_TLR:   state_nxt = tms_s ? S_TLR  : S_RTI;
      S_RTI:   state_nxt = tms_s ? S_SELD : S_RTI;
      S_SELD:  state_nxt = tms_s ? S_SELI : S_CAPD;
      S_CAPD:  state_nxt = tms_s ? S_EX1D : S_SHD;
      S_SHD:   state_nxt = tms_s ? S_EX1D : S_SHD;
      S_EX1D:  state_nxt = tms_s ? S_UPDD : S_PAUD;
      S_PAUD:  state_nxt = tms_s ? S_EX2D : S_PAUD;
      S_EX2D:  state_nxt = tms_s ? S_UPDD : S_SHD;
      S_UPDD:  state_nxt = tms_s ? S_SELD : S_RTI;
      S_SELI:  state_nxt = tms_s ? S_TLR  : S_CAPI;
      S_CAPI:  state_nxt = tms_s ? S_EX1I : S_SHI;
      S_SHI:   state_nxt = tms_s ? S_EX1I : S_SHI;
      S_EX1I:  state_nxt = tms_s ? S_UPDI : S_PAUI;
      S_PAUI:  state_nxt = tms_s ? S_EX2I : S_PAUI;
      S_EX2I:  state_nxt = tms_s ? S_UPDI : S_SHI;
      S_UPDI:  state_nxt = tms_s ? S_SELD : S_RTI;
      default: state_nxt = S_TLR;
    endcase
  end

  // State advances on each rising test clock edge
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      state_r <= S_TLR;
    else if (tck_rise)
      state_r <= state_nxt;
  end

  // Instruction decode; anything unknown falls to bypass
  always @* begin
    sel_ext  = 1'b0;
    sel_smp  = 1'b0;
    sel_id   = 1'b0;
    sel_user = 1'b0;
    sel_cfg  = 1'b0;
    sel_la   = 1'b0;
    sel_byp  = 1'b0;
    case (instr_r)
      `BST_OP_EXTEST:    sel_ext = 1'b1;
      `BST_OP_SAMPLE:    sel_smp = 1'b1;
      `BST_OP_IDCODE:    sel_id = 1'b1;
      `BST_OP_USERCODE:  sel_user = 1'b1;
      `BST_OP_CFG_LOAD:  sel_cfg = 1'b1;
      `BST_OP_LA_READ:   sel_la = 1'b1;
      default:           sel_byp = 1'b1;
    endcase
  end

  // Serial bit presented by the selected data register
  always @* begin
    dr_bit = byp_r;
    if (sel_ext | sel_smp)
      dr_bit = bsr_sr_r[0];
    else if (sel_id)
      dr_bit = id_sr_r[0];
    else if (sel_user)
      dr_bit = user_sr_r[0];
    else if (sel_cfg)
      dr_bit = cfg_sr_r;
    else if (sel_la)
      dr_bit = la_sr_r[0];
  end

  // Instruction path: capture, shift, update on falling edge
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ir_sr_r <= `BST_IR_CAPT;
      instr_r <= `BST_OP_IDCODE;
    end else if (state_r == S_TLR) begin
      instr_r <= `BST_OP_IDCODE;
    end else if (tck_rise && state_r == S_CAPI) begin
      ir_sr_r <= `BST_IR_CAPT;
    end else if (tck_rise && state_r == S_SHI) begin
      ir_sr_r <= {tdi_s, ir_sr_r[`BST_IR_LEN-1:1]};
    end else if (tck_fall && state_r == S_UPDI) begin
      instr_r <= ir_sr_r;
    end
  end

  // Bypass stage and configuration bit; every capture clears bypass
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      byp_r    <= `BST_BYP_RST;
      cfg_sr_r <= 1'b0;
    end else if (cap_dr) begin
      byp_r <= 1'b0;
    end else if (shift_dr) begin
      if (sel_byp)
        byp_r <= tdi_s;
      if (sel_cfg)
        cfg_sr_r <= tdi_s;
    end
  end

  // Identification reloads its fixed value on every capture
  bst_sreg #(
    .WIDTH   (`BST_WORD_LEN),
    .RST_VAL (ID_VALUE)
  ) u_id_sreg (
    .clock    (clock),
    .reset_n  (reset_n),
    .capture  (cap_dr & sel_id),
    .shift    (shift_dr & sel_id),
    .shift_in (tdi_s),
    .cap_val  (ID_VALUE),
    .sreg_r   (id_sr_r)
  );

  // User code is taken live from the core at capture
  bst_sreg #(
    .WIDTH   (`BST_WORD_LEN),
    .RST_VAL ({`BST_WORD_LEN{1'b0}})
  ) u_user_sreg (
    .clock    (clock),
    .reset_n  (reset_n),
    .capture  (cap_dr & sel_user),
    .shift    (shift_dr & sel_user),
    .shift_in (tdi_s),
    .cap_val  (user_code),
    .sreg_r   (user_sr_r)
  );

  // Analyzer snapshot; probes run at speed, frozen only at capture
  bst_sreg #(
    .WIDTH   (`BST_WORD_LEN),
    .RST_VAL ({`BST_WORD_LEN{1'b0}})
  ) u_la_sreg (
    .clock    (clock),
    .reset_n  (reset_n),
    .capture  (cap_dr & sel_la),
    .shift    (shift_dr & sel_la),
    .shift_in (tdi_s),
    .cap_val  (la_probe),
    .sreg_r   (la_sr_r)
  );

  // Boundary chain; pins captured live, pattern held until update
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bsr_sr_r  <= {BSR_LEN{1'b0}};
      bsr_upd_r <= {BSR_LEN{1'b0}};
    end else if (tck_rise && state_r == S_CAPD && (sel_ext | sel_smp)) begin
      bsr_sr_r <= pin_in;
    end else if (tck_rise && state_r == S_SHD && (sel_ext | sel_smp)) begin
      bsr_sr_r <= {tdi_s, bsr_sr_r[BSR_LEN-1:1]};
    end else if (tck_fall && state_r == S_UPDD && (sel_ext | sel_smp)) begin
      bsr_upd_r <= bsr_sr_r;
    end
  end

  // Pins follow core unless external test owns them
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_out       <= {BSR_LEN{1'b0}};
      extest_active <= 1'b0;
    end else begin
      pin_out       <= sel_ext ? bsr_upd_r : core_out;
      extest_active <= sel_ext;
    end
  end

  // Serial configuration stream, one strobe per shifted bit
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_bit    <= 1'b0;
      cfg_strobe <= 1'b0;
      cfg_start  <= 1'b0;
    end else begin
      cfg_strobe <= 1'b0;
      cfg_start  <= 1'b0;
      if (tck_rise && state_r == S_SHD && sel_cfg) begin
        cfg_bit    <= tdi_s;
        cfg_strobe <= 1'b1;
      end
      if (tck_fall && state_r == S_UPDI && ir_sr_r == `BST_OP_CFG_START)
        cfg_start <= 1'b1;
    end
  end

  // Data out changes on falling edge, driven only while shifting
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tdo_o     <= `BST_TDO_RST;
      tdo_oe    <= 1'b0;
      instr_out <= `BST_OP_IDCODE;
    end else begin
      instr_out <= instr_r;
      if (tck_fall) begin
        tdo_oe <= (state_r == S_SHD) | (state_r == S_SHI);
        tdo_o  <= (state_r == S_SHI) ? ir_sr_r[0] : dr_bit;
      end
    end
  end

endmodule

// Capture-and-shift register, bit 0 leaves first; WIDTH must be two or more
module bst_sreg #(
  parameter             WIDTH   = 32,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             clock,
  input  wire             reset_n,
  input  wire             capture,
  input  wire             shift,
  input  wire             shift_in,
  input  wire [WIDTH-1:0] cap_val,
  output reg  [WIDTH-1:0] sreg_r
);

  // Capture wins over shift; both are single-cycle strobes
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      sreg_r <= RST_VAL;
    else if (capture)
      sreg_r <= cap_val;
    else if (shift)
      sreg_r <= {shift_in, sreg_r[WIDTH-1:1]};
  end

endmodule

// >>> dv/bst_tap_chk.sv
`include "bst_map.vh"
module bst_tap_chk #(
  parameter BSR_LEN = `BST_BSR_LEN_SMALL
) (
  input wire                    clock,
  input wire                    reset_n,
  input wire                    tck,
  input wire                    tdo_o,
  input wire                    tdo_oe,
  input wire [BSR_LEN-1:0]      core_out,
  input wire [BSR_LEN-1:0]      pin_out,
  input wire                    extest_active,
  input wire                    cfg_strobe,
  input wire                    cfg_start,
  input wire [`BST_IR_LEN-1:0]  instr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Test clock is sampled late, so its phase is judged two clocks back
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  chk_pins_normal: assert property ($past(reset_n) && !extest_active && !$past(extest_active)
    |-> pin_out == $past(core_out)) else $error("pins differ from core values");
  chk_pins_held: assert property (extest_active && $past(extest_active) && $changed(pin_out)
    |-> !$past(tck, 2)) else $error("pins moved outside an update");
  chk_tdo_on_fall: assert property ($changed(tdo_o) || $changed(tdo_oe) |-> !$past(tck, 2))
    else $error("data out moved while test clock high");
  chk_strobe_rise: assert property (cfg_strobe
    |-> $past(tck, 2) && instr_out == `BST_OP_CFG_LOAD) else $error("stray config strobe");
  chk_strobe_pulse: assert property (cfg_strobe |=> !cfg_strobe)
    else $error("config strobe too long");
  chk_start_pulse: assert property (cfg_start |=> !cfg_start ##1 !cfg_start)
    else $error("config start repeated");
  chk_start_instr: assert property (cfg_start |-> ##[0:2] instr_out == `BST_OP_CFG_START)
    else $error("config start without its instruction");
  chk_extest_instr: assert property ($rose(extest_active)
    |-> ##[0:2] instr_out == `BST_OP_EXTEST) else $error("external test without instruction");
  cover property (cfg_strobe);
  cover property (cfg_start);
  cover property ($rose(extest_active));
endmodule

// >>> dv/bst_host.sv
module bst_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input  wire  tdo
);
  timeunit 1ns;
  timeprecision 1ns;
  // Test clock stands low between scans
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // Long low phase leaves the synchroniser time before tdo is read
  // Pins move by non-blocking assignment, as steps land on clock edges
  task step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    #100;
    q = tdo;
    tck <= 1'b1;
    #60;
    tck <= 1'b0;
  endtask
  // Five high mode bits reach reset from any state, then idle
  task reset_tap;
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
  // One scan from idle and back; tms goes high with the last shifted bit
  task scan(input bit ir, input int n, input logic [1694:0] din, output logic [1694:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) begin
      step(1'b1, 1'b0, q);
    end
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule

// >>> dv/testbench.sv
`include "bst_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = `BST_BSR_LEN_SMALL;
  typedef struct {logic [9:0] op; int n; logic [31:0] din; logic [31:0] exp;} bst_row_t;
  logic           clock = 1'b0;
  logic           reset_n = 1'b0;
  logic [31:0]    user_code = 32'hC3A50F96;
  logic [31:0]    la_probe = 32'h0F1E2D3C;
  logic [N-1:0]   pin_in = {375{3'h3}};
  logic [N-1:0]   core_out = {375{3'h6}};
  logic [1694:0]  pat = {565{3'h4}};
  logic [1694:0]  dout;
  wire  [N-1:0]   pin_out;
  wire  [9:0]     instr_out;
  wire            tck, tms, tdi, tdo_o, tdo_oe, extest_active, cfg_bit, cfg_strobe, cfg_start;
  int             fails = 0, checks_done = 0, strobes = 0, starts = 0;
  bst_row_t       rows[5];
  bst_tap uut (.clock(clock), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe), .user_code(user_code), .la_probe(la_probe),
    .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out), .extest_active(extest_active),
    .cfg_bit(cfg_bit), .cfg_strobe(cfg_strobe), .cfg_start(cfg_start), .instr_out(instr_out));
  bst_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_oe ? tdo_o : 1'bz));
  always #10 clock = ~clock;
  // Pulse counts; pulses are one clock, so a plain sum is exact
  always @(posedge clock) begin
    strobes <= strobes + cfg_strobe;
    starts <= starts + cfg_start;
  end
  task check(input string what, input logic [1694:0] seen, input logic [1694:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task load_ir(input logic [9:0] op);
    u_host.scan(1'b1, 10, op, dout);
    check("ir capture", dout, `BST_IR_CAPT);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog: a hang counts against the run
  initial begin
    repeat (50000) @(posedge clock);
    fails++;
    complete_run;
  end
  initial begin
    rows[0] = '{`BST_OP_IDCODE, 32, 32'h0,
      {`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MAKER, 1'h1}};
    rows[1] = '{`BST_OP_USERCODE, 32, 32'h0, user_code};
    rows[2] = '{`BST_OP_LA_READ, 32, 32'h0, la_probe};
    rows[3] = '{`BST_OP_BYPASS, 8, 32'hB5, 32'h6A};
    rows[4] = '{10'h155, 8, 32'hB5, 32'h6A};
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    check("instr", instr_out, `BST_OP_IDCODE);
    check("oe", tdo_oe, 1'h0);
    check("pins", pin_out, core_out);
    u_host.reset_tap;
    $display("test reset done");
    foreach (rows[k]) begin
      load_ir(rows[k].op);
      u_host.scan(1'b0, rows[k].n, rows[k].din, dout);
      check("dr out", dout, rows[k].exp);
      $display("test row %0d done", k);
    end
    // Sample while running normally, preloading the pattern for later
    load_ir(`BST_OP_SAMPLE);
    u_host.scan(1'b0, N, pat, dout);
    check("sample", dout, pin_in);
    check("pins", pin_out, core_out);
    load_ir(`BST_OP_EXTEST);
    check("extest", extest_active, 1'h1);
    check("driven", pin_out, pat[N-1:0]);
    u_host.scan(1'b0, N, pat, dout);
    check("captured", dout, pin_in);
    $display("test boundary done");
    // Configuration bits leave extest through an ordinary update
    load_ir(`BST_OP_CFG_LOAD);
    check("instr", instr_out, `BST_OP_CFG_LOAD);
    check("extest off", extest_active, 1'h0);
    u_host.scan(1'b0, 8, 8'hAD, dout);
    check("strobes", strobes, 8);
    check("cfg bit", cfg_bit, 1'h1);
    load_ir(`BST_OP_CFG_START);
    check("starts", starts, 1);
    u_host.reset_tap;
    check("instr", instr_out, `BST_OP_IDCODE);
    $display("test config done");
    // Reset in mid-run while external test owns the pins
    load_ir(`BST_OP_EXTEST);
    check("extest", extest_active, 1'h1);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    check("instr", instr_out, `BST_OP_IDCODE);
    check("extest off", extest_active, 1'h0);
    check("pins", pin_out, core_out);
    check("oe", tdo_oe, 1'h0);
    $display("test midrun reset done");
    complete_run;
  end
endmodule
bind bst_tap bst_tap_chk #(.BSR_LEN(BSR_LEN)) u_chk (.clock(clock), .reset_n(reset_n),
  .tck(tck), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .core_out(core_out), .pin_out(pin_out),
  .extest_active(extest_active), .cfg_strobe(cfg_strobe), .cfg_start(cfg_start),
  .instr_out(instr_out));
